// *** verilog/audio_irq_pkg.sv ***
// constants for the raw audio interrupt status block: register offsets,
// flag positions, reset value and the address decode helper.
// assumes a 12-bit byte address inside the audio register space.
`default_nettype none

package audio_irq_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int FLAG_W = 14;
	localparam int LOW_W = 7;

	// byte offsets of the two registers this block answers for
	localparam logic [ADDR_W-1:0] RAW_FLAGS_OFFSET = 12'h000;
	localparam logic [ADDR_W-1:0] FLAG_CLEAR_OFFSET = 12'h008;

	// flag positions inside the raw status word
	localparam int MODEM_STATUS_BIT = 13;
	localparam int READ_DONE_BIT = 12;
	localparam int WRITE_DONE_BIT = 11;
	localparam int CODEC_READY_BIT = 10;
	localparam int EXT_RX_ERR_BIT = 9;
	localparam int EXT_TX_ERR_BIT = 8;
	localparam int BUS_RX_ERR_BIT = 7;

	// reset value of the raw status word (bit 1, the transmit level flag)
	localparam logic [FLAG_W-1:0] FLAG_RESET = 14'h0002;
	localparam logic [DATA_W-FLAG_W-1:0] RESERVED_ZERO = 18'h00000;

	// address compare used by every decode term
	function automatic logic regHit(input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] offset);
		return addr == offset;
	endfunction

endpackage

`default_nettype wire

// *** verilog/audio_irq_flag_bank.sv ***
// sticky flag bank: each flag is set by its event and cleared by a one
// in the clear vector. assumes set and clear come from the same clock.
`timescale 1ns/1ps
`default_nettype none

module audio_irq_flag_bank
	import audio_irq_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [FLAG_W-1:0] setVec,
	input wire logic [FLAG_W-1:0] clrVec,
	output logic [FLAG_W-1:0] flags_q
);

	logic [FLAG_W-1:0] flags_d;

	// set wins over clear so an event landing on a clear is never lost
	always_comb begin
		flags_d = (flags_q & ~clrVec) | setVec;
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			flags_q <= FLAG_RESET;
		end else begin
			flags_q <= flags_d;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	AST_SET_BEATS_CLEAR: assert property (
		(setVec != '0) |=> ((flags_q & $past(setVec)) == $past(setVec)))
		else $error("a flag event was lost");

	AST_FLAG_HOLDS: assert property (
		(clrVec == '0) |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
		else $error("a flag dropped without a clear");

endmodule

`default_nettype wire

// *** verilog/audio_irq_raw_status.sv ***
// raw unmasked interrupt status of the audio serial interface, read over
// the APB, cleared through the write-only clear register.
// assumes all event inputs come from logic on ref_clk, single-cycle
// events except codecReadyTag, which is the level of the incoming tag bit.
`timescale 1ns/1ps
`default_nettype none

module audio_irq_raw_status
	import audio_irq_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	// apb slave
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// link and fifo events
	input wire logic ac97Mode,
	input wire logic modemStatusValid,
	input wire logic readDone,
	input wire logic writeDone,
	input wire logic codecReadyTag,
	input wire logic extRxOverrun,
	input wire logic extRxMisalign,
	input wire logic extTxUnderrun,
	input wire logic extTxMisalign,
	input wire logic busRxUnderrun,
	input wire logic busRxMisalign,
	input wire logic [LOW_W-1:0] lowEvents,
	// raw flags for the mask logic outside
	output logic [FLAG_W-1:0] rawFlags
);

	logic codecReadyPrev_q;
	logic codecReadyPrev_d;
	logic [DATA_W-1:0] prdata_q;
	logic [DATA_W-1:0] prdata_d;
	logic [FLAG_W-1:0] setVec;
	logic [FLAG_W-1:0] clrVec;
	logic [FLAG_W-1:0] flags;
	logic setupRead;
	logic accessPhase;
	logic hitRaw;
	logic hitClear;
	logic mapped;

	// apb phase and address decode
	assign hitRaw = regHit(paddr, RAW_FLAGS_OFFSET);
	assign hitClear = regHit(paddr, FLAG_CLEAR_OFFSET);
	assign setupRead = psel & ~penable & ~pwrite;
	assign accessPhase = psel & penable;
	// the status word is read-only and the clear word write-only
	assign mapped = (hitRaw & ~pwrite) | (hitClear & pwrite);

	// zero wait states: every transfer ends in its first access cycle
	assign pready = 1'b1;
	assign pslverr = accessPhase & ~mapped;

	// the tag bit is a level, so keep last cycle's value to see the rise;
	// the history runs in reset too, so a tag already high at release is
	// not taken for a fresh 0 to 1 transition
	always_comb begin
		codecReadyPrev_d = codecReadyTag;
	end

	always_ff @(posedge ref_clk) begin
		codecReadyPrev_q <= codecReadyPrev_d;
	end

	// event sources; link events are gated by the AC97 mode level
	always_comb begin
		setVec = '0;
		setVec[LOW_W-1:0] = lowEvents;
		setVec[MODEM_STATUS_BIT] = ac97Mode & modemStatusValid;
		setVec[READ_DONE_BIT] = ac97Mode & readDone;
		setVec[WRITE_DONE_BIT] = ac97Mode & writeDone;
		setVec[CODEC_READY_BIT] = ac97Mode & codecReadyTag
			& ~codecReadyPrev_q;
		setVec[EXT_RX_ERR_BIT] = extRxOverrun | extRxMisalign;
		setVec[EXT_TX_ERR_BIT] = extTxUnderrun | extTxMisalign;
		setVec[BUS_RX_ERR_BIT] = busRxUnderrun | busRxMisalign;
	end

	// a clear acts only in the access phase of a write to the clear word
	always_comb begin
		clrVec = '0;
		if (accessPhase && pwrite && hitClear) begin
			clrVec = pwdata[FLAG_W-1:0];
		end
	end

	audio_irq_flag_bank u_flags (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.setVec(setVec),
		.clrVec(clrVec),
		.flags_q(flags)
	);

	assign rawFlags = flags;

	// read data is sampled in the setup phase so it is a flop output in
	// the access phase; a read has no side effect on the flags
	always_comb begin
		prdata_d = prdata_q;
		if (setupRead) begin
			if (hitRaw) begin
				prdata_d = {RESERVED_ZERO, flags};
			end else begin
				prdata_d = '0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			prdata_q <= '0;
		end else begin
			prdata_q <= prdata_d;
		end
	end

	assign prdata = prdata_q;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	AST_MODEM_SET: assert property (
		ac97Mode && modemStatusValid |=> rawFlags[MODEM_STATUS_BIT])
		else $error("modem status event did not set its flag");

	AST_MODEM_CAUSE: assert property (
		$rose(rawFlags[MODEM_STATUS_BIT]) |->
			$past(ac97Mode) && $past(modemStatusValid))
		else $error("modem status flag rose without cause");

	AST_READ_DONE: assert property (
		$rose(rawFlags[READ_DONE_BIT]) |->
			$past(ac97Mode) && $past(readDone))
		else $error("read done flag rose without an AC97 read");

	AST_WRITE_DONE: assert property (
		ac97Mode && writeDone |=> rawFlags[WRITE_DONE_BIT])
		else $error("write done event did not set its flag");

	AST_CODEC_RISE: assert property (
		$rose(rawFlags[CODEC_READY_BIT]) |->
			$past(ac97Mode) && $past(codecReadyTag)
			&& !$past(codecReadyTag, 2))
		else $error("codec ready flag rose without a tag rise");

	AST_EXT_RX: assert property (
		extRxOverrun || extRxMisalign |=> rawFlags[EXT_RX_ERR_BIT])
		else $error("external receive error not flagged");

	AST_EXT_TX: assert property (
		extTxUnderrun || extTxMisalign |=> rawFlags[EXT_TX_ERR_BIT])
		else $error("external transmit error not flagged");

	AST_BUS_RX: assert property (
		busRxUnderrun || busRxMisalign |=> rawFlags[BUS_RX_ERR_BIT])
		else $error("bus receive error not flagged");

	AST_READ_VALUE: assert property (
		psel && !penable && !pwrite && hitRaw |=>
			prdata[FLAG_W-1:0] == $past(rawFlags))
		else $error("read data differs from raw flags");

	AST_CLEAR_ONLY: assert property (
		(($past(rawFlags) & ~rawFlags & ~$past(clrVec)) == '0))
		else $error("a flag fell without a clear write");

	AST_RESERVED_ZERO: assert property (
		psel && penable && !pwrite |-> prdata[DATA_W-1:FLAG_W] == '0)
		else $error("reserved bits read nonzero");

	AST_READ_DONE_SET: assert property (
		ac97Mode && readDone |=> rawFlags[READ_DONE_BIT])
		else $error("read done event did not set its flag");

	AST_WRITE_CAUSE: assert property (
		$rose(rawFlags[WRITE_DONE_BIT]) |->
			$past(ac97Mode) && $past(writeDone))
		else $error("write done flag rose without an AC97 write");

	AST_CODEC_SET: assert property (
		ac97Mode && codecReadyTag && !$past(codecReadyTag) |=>
			rawFlags[CODEC_READY_BIT])
		else $error("codec ready rise did not set its flag");

	AST_CLEAR_ACTS: assert property (
		accessPhase && pwrite && hitClear && (setVec == '0) |=>
			((rawFlags & $past(pwdata[FLAG_W-1:0])) == '0))
		else $error("a clear write left a flag set");

	AST_READ_NO_EFFECT: assert property (
		psel && !pwrite && (setVec == '0) |=>
			rawFlags == $past(rawFlags))
		else $error("a read changed the flags");

	COV_CODEC_READY: cover property (
		!codecReadyTag ##1 codecReadyTag && ac97Mode
			##1 rawFlags[CODEC_READY_BIT]);

	COV_SET_ON_CLEAR: cover property (
		(setVec & clrVec) != '0);

	// a write to the read-only word is refused
	COV_REFUSED_WRITE: cover property (
		psel && penable && pwrite && pslverr);

	COV_READ_CLEAR: cover property (
		psel && penable && !pwrite && hitRaw && prdata != '0
			##[1:8] psel && penable && pwrite && hitClear);

endmodule

`default_nettype wire

// *** testbench/codec_event_model.sv ***
// far-side model: codec link events and fifo faults as one-cycle pulses, the codec ready tag as a level
// assumes the bench requests events on ref_clk edges
`timescale 1ns/1ps
`default_nettype none

module codec_event_model (
	input wire logic ref_clk,
	input wire logic [8:0] kick,
	input wire logic tagReq,
	output logic [8:0] pulses,
	output logic codecReadyTag
);
	// one register stage, as the link logic would launch them
	always_ff @(posedge ref_clk) begin
		pulses <= kick;
		codecReadyTag <= tagReq;
	end
endmodule

`default_nettype wire

// *** testbench/audio_irq_raw_status_tb.sv ***
// bench for the raw audio flags: apb reads and clears, event stimulus
// assumes a zero wait state apb slave and the event model on ref_clk
`timescale 1ns/1ps
`default_nettype none

module audio_irq_raw_status_tb
	import audio_irq_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic ac97Mode = 1'b0;
	logic tagReq = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic [8:0] kick = '0;
	logic [8:0] pulses;
	logic codecReadyTag;
	logic [LOW_W-1:0] lowEvents = '0;
	logic [FLAG_W-1:0] rawFlags;
	logic [32:0] expQ[$];
	logic [32:0] e;
	logic [32:0] note;
	logic [31:0] lfsrQ = 32'h29cdfc17;
	int failures = 0;
	int cmp_count = 0;
	int bitOf[10] = '{MODEM_STATUS_BIT, READ_DONE_BIT, WRITE_DONE_BIT,
		EXT_RX_ERR_BIT, EXT_RX_ERR_BIT, EXT_TX_ERR_BIT, EXT_TX_ERR_BIT,
		BUS_RX_ERR_BIT, BUS_RX_ERR_BIT, CODEC_READY_BIT};

	// 200 MHz reference clock
	initial forever #2.5 ref_clk = ~ref_clk;

	codec_event_model u_model (
		.ref_clk(ref_clk),
		.kick(kick),
		.tagReq(tagReq),
		.pulses(pulses),
		.codecReadyTag(codecReadyTag)
	);

	audio_irq_raw_status u_dut (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.paddr(paddr),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.ac97Mode(ac97Mode),
		.modemStatusValid(pulses[0]),
		.readDone(pulses[1]),
		.writeDone(pulses[2]),
		.codecReadyTag(codecReadyTag),
		.extRxOverrun(pulses[3]),
		.extRxMisalign(pulses[4]),
		.extTxUnderrun(pulses[5]),
		.extTxMisalign(pulses[6]),
		.busRxUnderrun(pulses[7]),
		.busRxMisalign(pulses[8]),
		.lowEvents(lowEvents),
		.rawFlags(rawFlags)
	);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input logic [32:0] x, input logic [32:0] s);
		cmp_count++;
		if (s !== x) begin
			failures++;
			$display("wrong value read word expected %h seen %h", x, s);
		end
	endtask

	task automatic chkFlags(input logic [FLAG_W-1:0] x,
		input logic [FLAG_W-1:0] s);
		cmp_count++;
		if (s !== x) begin
			failures++;
			$display("wrong value raw flags expected %h seen %h", x, s);
		end
	endtask

	task automatic complete_run();
		if (failures == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// one apb transfer, entered just after an edge; zero wait states
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge, so the next call never re-drives psel in this step
		@(posedge ref_clk);
	endtask

	// x holds {pslverr, prdata} as expected
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [32:0] x);
		expQ.push_back(x);
		apb(1'b0, a, '0);
	endtask

	task automatic clr(input logic [FLAG_W-1:0] m);
		apb(1'b1, FLAG_CLEAR_OFFSET, {RESERVED_ZERO, m});
	endtask

	// request events for one cycle, then let them settle into the flags
	task automatic pulse(input logic [8:0] k);
		kick <= k;
		@(posedge ref_clk);
		kick <= '0;
		lowEvents <= '0;
		repeat (3) @(posedge ref_clk);
	endtask

	// scoreboard: each completed read takes the oldest note
	always @(posedge ref_clk) begin
		if (psel && penable && !pwrite && pready === 1'b1) begin
			note = expQ.pop_front();
			chk(note, {pslverr, prdata});
			if (paddr == RAW_FLAGS_OFFSET)
				chkFlags(note[FLAG_W-1:0], rawFlags);
		end
	end

	initial begin
		repeat (5) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		rd(RAW_FLAGS_OFFSET, 33'h2);
		clr(14'h3fff);
		rd(RAW_FLAGS_OFFSET, 33'h0);
		ac97Mode <= 1'b1;
		// every source once, random low events alongside
		for (int k = 0; k < 10; k++) begin
			lfsrQ = lfsr(lfsrQ);
			lowEvents <= lfsrQ[6:0];
			tagReq <= (k == 9);
			pulse((k < 9) ? (9'h1 << k) : 9'h0);
			e = {26'h0, lfsrQ[6:0]} | (33'h1 << bitOf[k]);
			rd(RAW_FLAGS_OFFSET, e);
			rd(RAW_FLAGS_OFFSET, e);
			clr(e[13:0] & 14'h3f80);
			rd(RAW_FLAGS_OFFSET, e & 33'h7f);
			clr(14'h7f);
			tagReq <= 1'b0;
			rd(RAW_FLAGS_OFFSET, 33'h0);
		end
		// link events outside ac97 operation leave no trace
		ac97Mode <= 1'b0;
		tagReq <= 1'b1;
		pulse(9'h007);
		rd(RAW_FLAGS_OFFSET, 33'h0);
		// a write to the read-only word must not clear anything
		pulse(9'h100);
		apb(1'b1, RAW_FLAGS_OFFSET, 32'hffffffff);
		rd(RAW_FLAGS_OFFSET, 33'h80);
		rd(FLAG_CLEAR_OFFSET, {1'b1, 32'h0});
		repeat (2) @(posedge ref_clk);
		if (expQ.size() != 0)
			failures++;
		complete_run();
	end
endmodule

`default_nettype wire
